// ==== hdl/rsg_room_select.sv ====
// Room select, accelerator enable routing and beam stop gating top
//
// Local design decisions: register access over AXI4-Lite and the register offsets.

// How it works
// RULE_01 - One selected room, zero to three
// RULE_02 - Four identical room channels
// RULE_03 - Room zero retracts its stop always
// RULE_04 - Unselected rooms one to three stay inserted
// RULE_05 - Switch picks hardwired or network selection
// RULE_06 - Controller sets switch for hardwired lines
// RULE_07 - Installer loops interlock outputs to inputs
// RULE_08 - Hardwired selection is two level bits
// RULE_09 - Selection always reported and readable
// RULE_10 - Accelerator enable follows selected room only
// RULE_11 - Stops inhibited unless permit relay energised
// RULE_12 - Until valid selection, stops and enable off (room zero stop still retracts before then)
module rsg_room_select (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_NRST,
   // AXI4-Lite write address
   input wire logic [rsg_pkg::ADDR_W-1:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   // AXI4-Lite write data
   input wire logic [rsg_pkg::DATA_W-1:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   // AXI4-Lite write response
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // AXI4-Lite read address
   input wire logic [rsg_pkg::ADDR_W-1:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   // AXI4-Lite read data
   output logic [rsg_pkg::DATA_W-1:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // Configuration and hardwired selection pins
   input wire logic I_SELECT_SOURCE_SWITCH,
   input wire logic [rsg_pkg::SEL_W-1:0] I_HW_SEL,
   // Room channels
   input wire logic [rsg_pkg::NUM_ROOMS-1:0] I_ROOM_BEAM_EN,
   input wire logic [rsg_pkg::NUM_ROOMS-1:0] I_ROOM_INTENSITY_RX_LINK,
   input wire logic [rsg_pkg::NUM_ROOMS-1:0] I_ROOM_STOP_REQ,
   output logic [rsg_pkg::NUM_ROOMS-1:0] O_ROOM_STATUS_TX_LINK,
   output logic [rsg_pkg::NUM_ROOMS-1:0] O_ROOM_STOP_DRIVE,
   // Interlock loop out and back
   output logic O_ILK_BEAM_EN,
   output logic [rsg_pkg::SEL_W-1:0] O_ILK_SEL,
   input wire logic I_ILK_BEAM_EN,
   input wire logic [rsg_pkg::SEL_W-1:0] I_ILK_SEL,
   input wire logic I_ILK_OK,
   // Accelerator side
   output logic O_ACC_ENABLE,
   output logic O_ACC_INTENSITY,
   // Selected room report contacts
   output logic [rsg_pkg::SEL_W-1:0] O_SEL_REPORT
);

   localparam int NR = rsg_pkg::NUM_ROOMS;
   localparam int SW = rsg_pkg::SEL_W;
   localparam int SYNC_W = 1 + SW + NR + NR + NR + 1 + SW + 1;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [SYNC_W-1:0] pins_async;
   logic [SYNC_W-1:0] pins_sync;
   logic src_hw;
   logic [SW-1:0] hw_sel;
   logic [NR-1:0] room_en;
   logic [NR-1:0] room_rx;
   logic [NR-1:0] room_req;
   logic ilk_en_ret;
   logic [SW-1:0] ilk_sel_ret;
   logic ilk_ok;

   assign pins_async = {I_SELECT_SOURCE_SWITCH, I_HW_SEL, I_ROOM_BEAM_EN,
                        I_ROOM_INTENSITY_RX_LINK, I_ROOM_STOP_REQ,
                        I_ILK_BEAM_EN, I_ILK_SEL, I_ILK_OK};

   rsg_sync #(
      .W(SYNC_W)
   ) u_sync (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_async(pins_async),
      .o_sync(pins_sync)
   );

   // Split the synchronised bundle
   assign {src_hw, hw_sel, room_en, room_rx, room_req,
           ilk_en_ret, ilk_sel_ret, ilk_ok} = pins_sync;

   ////////////////////////////////////////////////////////////////////////
   // Register decode helper

   function automatic logic is_adr(input logic [rsg_pkg::ADDR_W-1:0] a,
                                   input logic [rsg_pkg::ADDR_W-1:0] o);
      is_adr = (a == o);
   endfunction : is_adr

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path

   logic [rsg_pkg::ADDR_W-1:0] awaddr_reg;
   logic [SW-1:0] wsel_reg;
   logic wstrb0_reg;
   logic wr_fire;
   logic [SW-1:0] net_sel_reg;
   logic net_valid_reg;

   // Both halves held, no response outstanding
   assign wr_fire = !O_AWREADY && !O_WREADY && !O_BVALID;

   // Address channel, taken once per write
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_AWREADY <= 1'b1;
         awaddr_reg <= '0;
      end else if (I_AWVALID && O_AWREADY) begin
         O_AWREADY <= 1'b0;
         awaddr_reg <= I_AWADDR;
      end else if (O_BVALID && I_BREADY) begin
         O_AWREADY <= 1'b1;
      end
   end

   // Data channel, taken independently of the address
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_WREADY <= 1'b1;
         wsel_reg <= '0;
         wstrb0_reg <= 1'b0;
      end else if (I_WVALID && O_WREADY) begin
         O_WREADY <= 1'b0;
         wsel_reg <= I_WDATA[rsg_pkg::CTRL_SEL_LSB +: SW];
         wstrb0_reg <= I_WSTRB[0];
      end else if (O_BVALID && I_BREADY) begin
         O_WREADY <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_BVALID <= 1'b0;
         O_BRESP <= rsg_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         O_BVALID <= 1'b1;
         if (is_adr(awaddr_reg, rsg_pkg::ADR_CTRL)) begin
            O_BRESP <= rsg_pkg::RESP_OKAY;
         end else begin
            O_BRESP <= rsg_pkg::RESP_SLVERR;
         end
      end else if (O_BVALID && I_BREADY) begin
         O_BVALID <= 1'b0;
      end
   end

   // Network selection command
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         net_sel_reg <= rsg_pkg::CTRL_SEL_RST;
         net_valid_reg <= 1'b0;
      end else if (wr_fire && wstrb0_reg &&
                   is_adr(awaddr_reg, rsg_pkg::ADR_CTRL)) begin
         net_sel_reg <= wsel_reg; // RULE_05
         net_valid_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Selection source and settle state

   rsg_pkg::rsg_sel_state_t state_reg;
   rsg_pkg::rsg_sel_state_t state_next;
   logic [SW-1:0] sel_reg;
   logic [SW-1:0] sel_next;
   logic [SW-1:0] cand_sel;
   logic cand_ok;
   logic src_hw_reg;
   logic [rsg_pkg::SETTLE_W-1:0] settle_reg;
   logic sel_valid;

   // Candidate from the chosen source; hardwired lines ignored otherwise
   always_comb begin
      if (src_hw) begin
         cand_sel = hw_sel; // RULE_08
         cand_ok = 1'b1; // RULE_06
      end else begin
         cand_sel = net_sel_reg; // RULE_05
         cand_ok = net_valid_reg;
      end
   end

   // Selection must hold steady for the settle time before locking
   always_comb begin
      state_next = state_reg;
      sel_next = sel_reg;
      unique case (state_reg)
         rsg_pkg::SEL_WAIT: begin
            if (cand_ok && cand_sel == sel_reg && src_hw == src_hw_reg &&
                settle_reg == rsg_pkg::SETTLE_LAST) begin
               state_next = rsg_pkg::SEL_LOCKED;
            end
            sel_next = cand_sel;
         end
         rsg_pkg::SEL_LOCKED: begin
            if (!cand_ok || cand_sel != sel_reg || src_hw != src_hw_reg) begin
               state_next = rsg_pkg::SEL_WAIT; // RULE_01
               sel_next = cand_sel;
            end
         end
      endcase
   end

   // State and the one selected room
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_reg <= rsg_pkg::SEL_WAIT; // RULE_12
         sel_reg <= rsg_pkg::ROOM_ZERO;
         src_hw_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sel_reg <= sel_next; // RULE_01
         src_hw_reg <= src_hw;
      end
   end

   // Settle counter restarts on any change of candidate
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         settle_reg <= rsg_pkg::SETTLE_ZERO;
      end else if (state_reg != rsg_pkg::SEL_WAIT || !cand_ok ||
                   cand_sel != sel_reg || src_hw != src_hw_reg) begin
         settle_reg <= rsg_pkg::SETTLE_ZERO;
      end else if (settle_reg != rsg_pkg::SETTLE_LAST) begin
         settle_reg <= settle_reg + 1'b1;
      end
   end

   assign sel_valid = (state_reg == rsg_pkg::SEL_LOCKED);

   ////////////////////////////////////////////////////////////////////////
   // Interlock loop and permit relay

   logic permit;

   // Relay energises only while the loop is made and returns the selection that went out
   assign permit = ilk_ok && (ilk_sel_ret == O_ILK_SEL); // RULE_07

   // Signals sent round the interlock loop
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_ILK_BEAM_EN <= 1'b0;
         O_ILK_SEL <= rsg_pkg::ROOM_ZERO;
      end else begin
         O_ILK_BEAM_EN <= sel_valid && room_en[sel_reg]; // RULE_10
         O_ILK_SEL <= sel_reg;
      end
   end

   // Accelerator side, enable taken after the loop
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_ACC_ENABLE <= 1'b0; // RULE_12
         O_ACC_INTENSITY <= 1'b0;
      end else begin
         O_ACC_ENABLE <= sel_valid && permit && ilk_en_ret; // RULE_10
         O_ACC_INTENSITY <= sel_valid && room_rx[sel_reg];
      end
   end

   // Selection report contacts
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_SEL_REPORT <= rsg_pkg::ROOM_ZERO;
      end else begin
         O_SEL_REPORT <= sel_reg; // RULE_09
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Identical room channels

   genvar gi;
   generate
      for (gi = 0; gi < NR; gi++) begin : g_room
         // Beam stop gate, room zero entitled always
         rsg_room_gate u_gate (
            .i_clk(I_CLK),
            .i_nrst(I_NRST),
            .i_req(room_req[gi]),
            .i_always(gi == 0), // RULE_03
            .i_selected(sel_reg == SW'(gi)), // RULE_04
            .i_valid(sel_valid),
            .i_permit(permit), // RULE_11
            .o_drive(O_ROOM_STOP_DRIVE[gi])
         );

         // Status link tells the room it holds control
         always_ff @(posedge I_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               O_ROOM_STATUS_TX_LINK[gi] <= 1'b0;
            end else begin
               O_ROOM_STATUS_TX_LINK[gi] <= sel_valid &&
                                           sel_reg == SW'(gi); // RULE_02
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   logic [rsg_pkg::DATA_W-1:0] status_word;
   logic [rsg_pkg::DATA_W-1:0] ctrl_word;

   // Live status word
   always_comb begin
      status_word = '0;
      status_word[rsg_pkg::ST_SEL_LSB +: SW] = sel_reg; // RULE_09
      status_word[rsg_pkg::ST_VALID_BIT] = sel_valid;
      status_word[rsg_pkg::ST_HWSRC_BIT] = src_hw;
      status_word[rsg_pkg::ST_PERMIT_BIT] = permit;
      status_word[rsg_pkg::ST_ACCEN_BIT] = O_ACC_ENABLE;
      status_word[rsg_pkg::ST_EN_LSB +: NR] = room_en;
      status_word[rsg_pkg::ST_DRIVE_LSB +: NR] = O_ROOM_STOP_DRIVE;
      status_word[rsg_pkg::ST_REQ_LSB +: NR] = room_req;
   end

   // Control readback
   always_comb begin
      ctrl_word = '0;
      ctrl_word[rsg_pkg::CTRL_SEL_LSB +: SW] = net_sel_reg;
      ctrl_word[rsg_pkg::CTRL_VALID_BIT] = net_valid_reg;
   end

   // Read address accept
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_ARREADY <= 1'b1;
      end else if (I_ARVALID && O_ARREADY) begin
         O_ARREADY <= 1'b0;
      end else if (O_RVALID && I_RREADY) begin
         O_ARREADY <= 1'b1;
      end
   end

   // Read data and response, one cycle after the address
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_RVALID <= 1'b0;
         O_RDATA <= '0;
         O_RRESP <= rsg_pkg::RESP_OKAY;
      end else if (I_ARVALID && O_ARREADY) begin
         O_RVALID <= 1'b1;
         if (is_adr(I_ARADDR, rsg_pkg::ADR_CTRL)) begin
            O_RDATA <= ctrl_word;
            O_RRESP <= rsg_pkg::RESP_OKAY;
         end else if (is_adr(I_ARADDR, rsg_pkg::ADR_STATUS)) begin
            O_RDATA <= status_word; // RULE_09
            O_RRESP <= rsg_pkg::RESP_OKAY;
         end else begin
            O_RDATA <= '0;
            O_RRESP <= rsg_pkg::RESP_SLVERR;
         end
      end else if (O_RVALID && I_RREADY) begin
         O_RVALID <= 1'b0;
      end
   end

endmodule : rsg_room_select

// ==== hdl/rsg_pkg.sv ====
// Constants and types shared by the room select and beam stop gating block
package rsg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int NUM_ROOMS = 4;
   localparam int SEL_W = 2;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [SEL_W-1:0] ROOM_ZERO = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADR_STATUS = 4'h4;

   // Control register fields
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_VALID_BIT = 2;
   localparam logic [SEL_W-1:0] CTRL_SEL_RST = 2'h0;

   // Status register fields
   localparam int ST_SEL_LSB = 0;
   localparam int ST_VALID_BIT = 2;
   localparam int ST_HWSRC_BIT = 3;
   localparam int ST_PERMIT_BIT = 4;
   localparam int ST_ACCEN_BIT = 5;
   localparam int ST_EN_LSB = 8;
   localparam int ST_DRIVE_LSB = 12;
   localparam int ST_REQ_LSB = 16;

   ////////////////////////////////////////////////////////////////////////
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 8;
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);
   localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 8'h00;

   // Selection state
   typedef enum logic [0:0] {
      SEL_WAIT,
      SEL_LOCKED
   } rsg_sel_state_t;

endpackage : rsg_pkg

// ==== hdl/rsg_sync.sv ====
// Two flip-flop synchroniser bank for pin inputs
module rsg_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_reg;

   // First stage is read only by the second stage
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end

endmodule : rsg_sync

// ==== hdl/rsg_room_gate.sv ====
// Beam stop retract gate for one room
module rsg_room_gate (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Gate conditions
   input wire logic i_req,
   input wire logic i_always,
   input wire logic i_selected,
   input wire logic i_valid,
   input wire logic i_permit,
   // Solenoid drive
   output logic o_drive
);

   logic drive_next;

   // Retract only with relay energised and the room entitled
   always_comb begin
      drive_next = 1'b0;
      if (i_permit && i_req) begin // RULE_11
         if (i_always) begin
            drive_next = 1'b1; // RULE_03
         end else if (i_valid && i_selected) begin // RULE_12
            drive_next = 1'b1; // RULE_04
         end
      end
   end

   // Registered drive, inserted from reset
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_drive <= 1'b0;
      end else begin
         o_drive <= drive_next;
      end
   end

endmodule : rsg_room_gate

// ==== dv/rsg_far_side.sv ====
// Interlock loop partner that stands outside the room select block
module rsg_far_side (
   // Loop outputs of the block
   input wire logic i_beam_en,
   input wire logic [rsg_pkg::SEL_W-1:0] i_sel,
   // Opens the loop on demand
   input wire logic i_break,
   // Loop returns
   output logic o_beam_en,
   output logic [rsg_pkg::SEL_W-1:0] o_sel,
   output logic o_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   // Made loop passes through; an open one returns the selection inverted and drops beam enable and ok
   always_comb begin
      o_ok = !i_break;
      o_beam_en = i_beam_en & !i_break;
      o_sel = i_break ? ~i_sel : i_sel;
   end
endmodule : rsg_far_side

// ==== dv/rsg_room_select_properties.sv ====
// Concurrent checks on the room select block ports
module rsg_room_select_checker (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_NRST,
   // Bus handshakes
   input wire logic I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY,
   input wire logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID,
   input wire logic [1:0] O_BRESP,
   input wire logic [1:0] O_RRESP,
   input wire logic [rsg_pkg::DATA_W-1:0] O_RDATA,
   // Rooms and loop
   input wire logic [rsg_pkg::NUM_ROOMS-1:0] I_ROOM_STOP_REQ,
   input wire logic [rsg_pkg::NUM_ROOMS-1:0] O_ROOM_STATUS_TX_LINK,
   input wire logic [rsg_pkg::NUM_ROOMS-1:0] O_ROOM_STOP_DRIVE,
   input wire logic [rsg_pkg::SEL_W-1:0] O_ILK_SEL,
   input wire logic [rsg_pkg::SEL_W-1:0] I_ILK_SEL,
   input wire logic I_ILK_BEAM_EN, I_ILK_OK, O_ACC_ENABLE,
   input wire logic [rsg_pkg::SEL_W-1:0] O_SEL_REPORT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dcb @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);
   ///////////////////////////////////////////////////////////////////////
   // Selection and gating
   a_one_room: assert property ($onehot0(O_ROOM_STATUS_TX_LINK))
      else $error("two rooms selected");
   a_status_sel: assert property (
      (|O_ROOM_STATUS_TX_LINK) && $stable(O_SEL_REPORT)
      |-> O_ROOM_STATUS_TX_LINK == (4'h1 << O_SEL_REPORT))
      else $error("status link disagrees with report");
   a_room0_free: assert property (
      (I_ROOM_STOP_REQ[0] && I_ILK_OK && I_ILK_SEL == O_ILK_SEL
      && $stable(O_ILK_SEL)) [*5] |-> O_ROOM_STOP_DRIVE[0])
      else $error("room zero stop not retracted");
   a_unsel_inserted: assert property (
      (O_ROOM_STOP_DRIVE[3:1] & ~O_ROOM_STATUS_TX_LINK[3:1]) == 3'h0)
      else $error("unselected room stop retracted");
   a_stop_permit: assert property (
      (|O_ROOM_STOP_DRIVE) |-> $past(I_ILK_OK, 3))
      else $error("stop driven without permit");
   a_acc_loop: assert property (
      O_ACC_ENABLE |-> $past(I_ILK_BEAM_EN, 3) && (|O_ROOM_STATUS_TX_LINK))
      else $error("accelerator enable without cause");
   ///////////////////////////////////////////////////////////////////////
   // Register bus
   a_rd_answer: assert property (
      I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
      else $error("read answer late");
   a_rd_hold: assert property (
      O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA)
      && $stable(O_RRESP))
      else $error("read answer not held");
   a_wr_answer: assert property (
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
      |=> !O_AWREADY && !O_WREADY ##1 O_BVALID)
      else $error("write answer late");
   a_wr_hold: assert property (
      O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write answer not held");
endmodule : rsg_room_select_checker

bind rsg_room_select rsg_room_select_checker rsg_room_select_checker_inst (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_AWVALID(I_AWVALID),
   .I_WVALID(I_WVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
   .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY),
   .O_BVALID(O_BVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
   .O_BRESP(O_BRESP), .O_RRESP(O_RRESP), .O_RDATA(O_RDATA),
   .I_ROOM_STOP_REQ(I_ROOM_STOP_REQ),
   .O_ROOM_STATUS_TX_LINK(O_ROOM_STATUS_TX_LINK),
   .O_ROOM_STOP_DRIVE(O_ROOM_STOP_DRIVE), .O_ILK_SEL(O_ILK_SEL),
   .I_ILK_SEL(I_ILK_SEL), .I_ILK_BEAM_EN(I_ILK_BEAM_EN),
   .I_ILK_OK(I_ILK_OK), .O_ACC_ENABLE(O_ACC_ENABLE),
   .O_SEL_REPORT(O_SEL_REPORT));

// ==== dv/rsg_room_select_bench.sv ====
// Self-checking bench for the room select block
module rsg_room_select_bench;
   timeunit 1ns;
   timeprecision 1ps;
   ///////////////////////////////////////////////////////////////////////
   // Signals
   logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
   logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, src_sw, brk;
   logic ilk_en_out, ilk_en_in, ilk_ok, acc_en, acc_int;
   logic [3:0] awaddr, araddr, wstrb, beam_en, intens, stop_req;
   logic [3:0] status, drive, tx_m, m;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, hw_sel, ilk_sel_out, ilk_sel_in, sel_rep;
   int errors, n_tests, r;
   ///////////////////////////////////////////////////////////////////////
   // Design and loop partner
   rsg_room_select rsg_room_select_inst (
      .I_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(aw_rdy), .I_WDATA(wdata), .I_WSTRB(wstrb),
      .I_WVALID(wvalid), .O_WREADY(w_rdy), .O_BRESP(bresp),
      .O_BVALID(b_vld), .I_BREADY(bready), .I_ARADDR(araddr),
      .I_ARVALID(arvalid), .O_ARREADY(ar_rdy), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(r_vld), .I_RREADY(rready),
      .I_SELECT_SOURCE_SWITCH(src_sw), .I_HW_SEL(hw_sel),
      .I_ROOM_BEAM_EN(beam_en), .I_ROOM_INTENSITY_RX_LINK(intens),
      .I_ROOM_STOP_REQ(stop_req), .O_ROOM_STATUS_TX_LINK(status),
      .O_ROOM_STOP_DRIVE(drive), .O_ILK_BEAM_EN(ilk_en_out),
      .O_ILK_SEL(ilk_sel_out), .I_ILK_BEAM_EN(ilk_en_in),
      .I_ILK_SEL(ilk_sel_in), .I_ILK_OK(ilk_ok), .O_ACC_ENABLE(acc_en),
      .O_ACC_INTENSITY(acc_int), .O_SEL_REPORT(sel_rep));
   rsg_far_side rsg_far_side_inst (
      .i_beam_en(ilk_en_out), .i_sel(ilk_sel_out), .i_break(brk),
      .o_beam_en(ilk_en_in), .o_sel(ilk_sel_in), .o_ok(ilk_ok));
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ///////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // Write with both channels offered together, response ready held high
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] s, input logic [1:0] er);
      int k;
      logic [1:0] resp;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 60; k++) begin
         @(posedge clk);
         if (b_vld) break;
         if (aw_rdy) awvalid <= 1'b0;
         if (w_rdy) wvalid <= 1'b0;
      end
      resp = bresp;
      bready <= 1'b0;
      if (k == 60) begin
         errors++;
         final_report();
      end
      // One idle edge keeps the next call off this step
      @(posedge clk);
      check(32'(resp), 32'(er));
   endtask : axi_write
   // Read with data ready held high, data taken at the handshake edge
   task automatic axi_read(input logic [3:0] a, input logic [31:0] exp,
                           input logic [1:0] er);
      int k;
      logic [31:0] data;
      logic [1:0] resp;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 60; k++) begin
         @(posedge clk);
         if (r_vld) break;
         if (ar_rdy) arvalid <= 1'b0;
      end
      data = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (k == 60) begin
         errors++;
         final_report();
      end
      @(posedge clk);
      check(data, exp);
      check(32'(resp), 32'(er));
   endtask : axi_read
   // Waits until the room status lines show the given pattern
   task automatic wait_status(input logic [3:0] exp);
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge clk);
         if (status === exp) break;
      end
      check(32'(status), 32'(exp));
      if (k == 400) final_report();
   endtask : wait_status
   ///////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      errors = 0;
      n_tests = 0;
      {nrst, awvalid, wvalid, bready, arvalid, rready, src_sw, brk} = 8'h0;
      {awaddr, araddr, wstrb, wdata, hw_sel, intens} = 50'h0;
      beam_en = 4'hf;
      stop_req = 4'hf;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      check(32'(drive), 32'h1);
      check(32'({status, acc_en}), 32'h0);
      axi_read(rsg_pkg::ADR_CTRL, 32'h0, rsg_pkg::RESP_OKAY);
      // Every room chosen over the bus in turn
      for (r = 0; r < 4; r++) begin
         m = 4'h1 << r;
         tx_m = m | 4'h1;
         axi_write(rsg_pkg::ADR_CTRL, 32'(r), 4'hf,
            rsg_pkg::RESP_OKAY);
         wait_status(m);
         repeat (6) @(posedge clk);
         check(32'(sel_rep), 32'(r));
         check(32'(drive), 32'(tx_m));
         axi_read(rsg_pkg::ADR_STATUS, {12'h0, 4'hf, tx_m, 4'hf,
            8'h34 | 8'(r)}, rsg_pkg::RESP_OKAY);
         beam_en <= ~m;
         intens <= ~m;
         repeat (10) @(posedge clk);
         check(32'({acc_en, acc_int}), 32'h0);
         beam_en <= m;
         intens <= m;
         repeat (10) @(posedge clk);
         check(32'({acc_en, acc_int}), 32'h3);
         beam_en <= 4'hf;
      end
      // Refused and strobe-less accesses leave the control word alone
      axi_write(rsg_pkg::ADR_CTRL, 32'h1, 4'h0, rsg_pkg::RESP_OKAY);
      axi_write(rsg_pkg::ADR_STATUS, 32'h0, 4'hf,
         rsg_pkg::RESP_SLVERR);
      axi_write(4'h8, 32'h0, 4'hf, rsg_pkg::RESP_SLVERR);
      axi_read(4'hc, 32'h0, rsg_pkg::RESP_SLVERR);
      axi_read(rsg_pkg::ADR_CTRL, 32'h7, rsg_pkg::RESP_OKAY);
      // Hardwired pins take over; a bus write meanwhile is stored and takes effect only on return to the network
      src_sw <= 1'b1;
      hw_sel <= 2'h2;
      wait_status(4'h4);
      axi_write(rsg_pkg::ADR_CTRL, 32'h1, 4'hf, rsg_pkg::RESP_OKAY);
      repeat (150) @(posedge clk);
      check(32'(sel_rep), 32'h2);
      src_sw <= 1'b0;
      wait_status(4'h2);
      // Opening the loop drops every stop and the enable
      brk <= 1'b1;
      repeat (6) @(posedge clk);
      check(32'({acc_en, drive}), 32'h0);
      brk <= 1'b0;
      repeat (6) @(posedge clk);
      check(32'(drive), 32'h3);
      final_report();
   end
endmodule : rsg_room_select_bench
